// [pmw_flag.sv]
`timescale 1ns/1ps
`default_nettype none
module pmw_flag
  import pmw_pkg::*;
(
  input wire logic sys_clk, // System clock
  input wire logic reset, // Sync reset
  input wire logic event_in, // Event level
  input wire logic clear, // Clear strobe
  output logic flag // Sticky flag
);
  logic event_q;
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      event_q <= 1'b0;
    end else begin
      event_q <= event_in;
    end
  end
  // Rising edge sets; set beats a same-cycle clear
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      flag <= 1'b0;
    end else if (event_in && !event_q) begin
      flag <= 1'b1;
    end else if (clear) begin
      flag <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// [pmw_pkg.sv]
package pmw_pkg;
  localparam logic [7:0] PMW_ADDR_CONTROL = 8'h87;
  localparam logic [7:0] PMW_ADDR_WAKE_CONFIG = 8'hB5;
  localparam logic [7:0] PMW_ADDR_MODE_OPTIONS = 8'hB6;
  localparam int PMW_BIT_SLEEP = 7;
  localparam int PMW_BIT_SUSPEND = 6;
  localparam int PMW_BIT_CLEAR = 5;
  localparam int PMW_BIT_RESET_PIN = 4;
  localparam int PMW_BIT_RTC_FAIL = 3;
  localparam int PMW_BIT_RTC_ALARM = 2;
  localparam int PMW_BIT_PORT_MATCH = 1;
  localparam int PMW_BIT_COMP_EDGE = 0;
  localparam int PMW_BIT_RTC_OUT_EN = 7;
  localparam int PMW_BIT_WAKE_OUT_EN = 6;
  localparam int PMW_BIT_MON_OFF = 5;
  localparam int PMW_BIT_STOP = 1;
  localparam int PMW_BIT_IDLE = 0;
  localparam int PMW_GF_LSB = 2;
  localparam int PMW_GF_MSB = 7;
  localparam int PMW_NUM_WAKE_SRC = 4;
  localparam logic [7:0] PMW_CONTROL_RESET = 8'h00;
  localparam logic [7:0] PMW_MODE_RESET = 8'h00;
  localparam logic [1:0] PMW_FLAG_HOLD_CLKS = 2'h2;
  typedef enum logic [1:0] {
    PMW_RUN = 2'b00,
    PMW_IDLE = 2'b01,
    PMW_STOP = 2'b10,
    PMW_LOWPWR = 2'b11
  } pmw_state_t;
endpackage

// [pmw_power_mode_wakeup.sv]
// Overview of operation
// - Bit 7 write one enters sleep
// - Bit 6 write one enters suspend
// - Bit 5 write one clears flags
// - Bit 4 reads reset-pin fall flag
// - Bit 3 enables/reads oscillator fail
// - Bit 2 enables/reads alarm
// - Bit 1 enables/reads port match
// - Bit 0 enables/reads comparator edge
// - Set flag blocks suspend or sleep
// - Flags read zero two clocks after suspend
// - Mode bit 7 enables clock output
// - Mode bit 6 routes wake request
// - Mode bit 5 disables battery monitor
// - Mode bits 4:0 read zero
// - Control bits 7:2 general flags
// - Control bit 1 enters stop
// - Control bit 0 enters idle
// - Wake request high awake, low asleep
// - Reset when monitor off requests POR
// - Reset-pin fall always wakes sleep
// - Flags set regardless of enables
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module pmw_power_mode_wakeup
  import pmw_pkg::*;
(
  input wire logic sys_clk, // 20 MHz system clock
  input wire logic reset, // Sync reset, active high
  input wire logic [7:0] reg_addr, // Register address
  input wire logic [7:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output logic [7:0] reg_rdata, // Read data, cycle after strobe
  input wire logic reset_pin_n, // Reset pin level
  input wire logic rtc_osc_fail, // Oscillator failed level
  input wire logic rtc_alarm, // Alarm event level
  input wire logic port_match, // Port match level
  input wire logic comparator_out, // Comparator0 output
  input wire logic rtc_clk_in, // Oscillator clock level
  input wire logic any_reset_src, // Any reset source active
  input wire logic wake_interrupt, // Interrupt wakes idle
  output logic [1:0] power_state, // Current power mode
  output logic lpo_keep_on, // Keep low power osc on
  output logic rtc_out, // Buffered clock pin
  output logic rtc_out_oe, // Clock pin drive enable
  output logic wake_req_out, // Wake request pin
  output logic wake_req_oe, // Wake request drive enable
  output logic battery_monitor_off, // Monitor disabled
  output logic full_por_req // Full power-on reset request
);
  ////////////////////////////////////////////////////////////////////////
  logic wr_ctrl;
  logic wr_wake;
  logic wr_mode;
  logic clear_strobe;
  logic [PMW_NUM_WAKE_SRC:0] wake_events;
  logic [PMW_NUM_WAKE_SRC:0] flags;
  logic [PMW_NUM_WAKE_SRC-1:0] wake_enable;
  logic [5:0] general_flags;
  logic [7:0] mode_opts;
  logic [1:0] hold_cnt;
  logic from_suspend;
  logic lowpwr_sleep;
  logic sources_hit;
  logic flags_any;
  logic [7:0] next_rdata;
  pmw_state_t state;

  assign wr_ctrl = reg_wr && (reg_addr == PMW_ADDR_CONTROL);
  assign wr_wake = reg_wr && (reg_addr == PMW_ADDR_WAKE_CONFIG);
  assign wr_mode = reg_wr && (reg_addr == PMW_ADDR_MODE_OPTIONS);
  assign clear_strobe = wr_wake && reg_wdata[PMW_BIT_CLEAR];
  assign wake_events = {!reset_pin_n, rtc_osc_fail, rtc_alarm, port_match,
                        comparator_out};

  ////////////////////////////////////////////////////////////////////////
  // One sticky flag per source, edge triggered
  genvar gi;
  generate
    for (gi = 0; gi <= PMW_NUM_WAKE_SRC; gi++) begin : g_flag
      pmw_flag u_flag (
        .sys_clk(sys_clk),
        .reset(reset),
        .event_in(wake_events[gi]),
        .clear(clear_strobe),
        .flag(flags[gi])
      );
    end
  endgenerate
  assign flags_any = |flags;

  ////////////////////////////////////////////////////////////////////////
  // Enables are write-only and held until the next wake-config write
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      wake_enable <= '0;
    end else if (wr_wake) begin
      wake_enable <= reg_wdata[PMW_BIT_RTC_FAIL:PMW_BIT_COMP_EDGE];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      general_flags <= PMW_CONTROL_RESET[PMW_GF_MSB:PMW_GF_LSB];
    end else if (wr_ctrl) begin
      general_flags <= reg_wdata[PMW_GF_MSB:PMW_GF_LSB];
    end
  end

  // Monitor disable survives only until the next reset
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      mode_opts <= PMW_MODE_RESET;
    end else if (wr_mode) begin
      mode_opts <= {reg_wdata[7:5], 5'h00};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  assign sources_hit = |(flags[PMW_NUM_WAKE_SRC-1:0] & wake_enable);

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state <= PMW_RUN;
      lowpwr_sleep <= 1'b0;
      from_suspend <= 1'b0;
    end else begin
      from_suspend <= 1'b0;
      unique case (state)
        PMW_RUN: begin
          if (wr_wake && reg_wdata[PMW_BIT_SLEEP] && !flags_any) begin
            state <= PMW_LOWPWR;
            lowpwr_sleep <= 1'b1;
          end else if (wr_wake && reg_wdata[PMW_BIT_SUSPEND] && !flags_any) begin
            state <= PMW_LOWPWR;
            lowpwr_sleep <= 1'b0;
          end else if (wr_ctrl && reg_wdata[PMW_BIT_STOP]) begin
            state <= PMW_STOP;
          end else if (wr_ctrl && reg_wdata[PMW_BIT_IDLE]) begin
            state <= PMW_IDLE;
          end
        end
        PMW_IDLE: begin
          if (wake_interrupt) begin
            state <= PMW_RUN;
          end
        end
        PMW_STOP: begin
          // Only a reset leaves stop
          state <= PMW_STOP;
        end
        PMW_LOWPWR: begin
          if (sources_hit || flags[PMW_BIT_RESET_PIN]) begin
            state <= PMW_RUN;
            from_suspend <= !lowpwr_sleep;
          end
        end
      endcase
    end
  end

  // Flag reads masked for two clocks after suspend wake
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      hold_cnt <= 2'h0;
    end else if (from_suspend) begin
      hold_cnt <= PMW_FLAG_HOLD_CLKS - 2'h1;
    end else if (hold_cnt != 2'h0) begin
      hold_cnt <= hold_cnt - 2'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_rdata = 8'h00;
    unique case (reg_addr)
      PMW_ADDR_CONTROL: next_rdata = {general_flags, 2'b00};
      PMW_ADDR_WAKE_CONFIG: begin
        if (!from_suspend && hold_cnt == 2'h0) begin
          next_rdata = {3'b000, flags};
        end
      end
      PMW_ADDR_MODE_OPTIONS: next_rdata = mode_opts;
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      power_state <= PMW_RUN;
      lpo_keep_on <= 1'b0;
      rtc_out <= 1'b0;
      rtc_out_oe <= 1'b0;
      wake_req_out <= 1'b0;
      wake_req_oe <= 1'b0;
      battery_monitor_off <= 1'b0;
      full_por_req <= 1'b0;
    end else begin
      power_state <= state;
      lpo_keep_on <= flags_any;
      rtc_out <= rtc_clk_in && mode_opts[PMW_BIT_RTC_OUT_EN];
      rtc_out_oe <= mode_opts[PMW_BIT_RTC_OUT_EN];
      wake_req_out <= !(state == PMW_LOWPWR && lowpwr_sleep);
      wake_req_oe <= mode_opts[PMW_BIT_WAKE_OUT_EN];
      battery_monitor_off <= mode_opts[PMW_BIT_MON_OFF];
      full_por_req <= any_reset_src && mode_opts[PMW_BIT_MON_OFF];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  property p_sleep_blocked;
    @(posedge sys_clk) disable iff (reset)
      (state == PMW_RUN && wr_wake && reg_wdata[PMW_BIT_SLEEP] && flags_any)
      |=> state != PMW_LOWPWR;
  endproperty
  a_sleep_blocked: assert property (p_sleep_blocked) else $error("entered low power with flag");

  property p_clear;
    @(posedge sys_clk) disable iff (reset)
      (clear_strobe && wake_events == '0) |=> flags == '0;
  endproperty
  a_clear: assert property (p_clear) else $error("clear failed");

  property p_mode_low_zero;
    @(posedge sys_clk) disable iff (reset)
      (reg_rd && reg_addr == PMW_ADDR_MODE_OPTIONS) |=> reg_rdata[4:0] == 5'h00;
  endproperty
  a_mode_low_zero: assert property (p_mode_low_zero) else $error("mode low bits nonzero");

  property p_gf;
    @(posedge sys_clk) disable iff (reset)
      wr_ctrl ##1 (reg_rd && reg_addr == PMW_ADDR_CONTROL && !wr_ctrl)
      |=> reg_rdata[7:2] == $past(reg_wdata[7:2], 2);
  endproperty
  a_gf: assert property (p_gf) else $error("general flags lost");

  property p_stop;
    @(posedge sys_clk) disable iff (reset)
      (state == PMW_RUN && wr_ctrl && reg_wdata[PMW_BIT_STOP] && !wr_wake)
      |=> state == PMW_STOP ##1 power_state == PMW_STOP;
  endproperty
  a_stop: assert property (p_stop) else $error("stop not entered");

  property p_suspend_mask;
    @(posedge sys_clk) disable iff (reset)
      from_suspend ##0 (reg_rd && reg_addr == PMW_ADDR_WAKE_CONFIG)
      |=> reg_rdata == 8'h00;
  endproperty
  a_suspend_mask: assert property (p_suspend_mask) else $error("flags visible early");

  property p_pin_wake;
    @(posedge sys_clk) disable iff (reset)
      (state == PMW_LOWPWR && flags[PMW_BIT_RESET_PIN]) |=> state == PMW_RUN;
  endproperty
  a_pin_wake: assert property (p_pin_wake) else $error("pin did not wake");

  property p_wake_req;
    @(posedge sys_clk) disable iff (reset)
      (state == PMW_LOWPWR && lowpwr_sleep) |=> !wake_req_out;
  endproperty
  a_wake_req: assert property (p_wake_req) else $error("wake request high asleep");

  property p_por;
    @(posedge sys_clk) disable iff (reset)
      (any_reset_src && battery_monitor_off && !wr_mode && !$past(wr_mode))
      |=> full_por_req;
  endproperty
  a_por: assert property (p_por) else $error("no full reset request");

  property p_sleep_entry;
    @(posedge sys_clk) disable iff (reset)
      (state == PMW_RUN && wr_wake && reg_wdata[PMW_BIT_SLEEP] && !flags_any)
      |=> state == PMW_LOWPWR && lowpwr_sleep;
  endproperty
  a_sleep_entry: assert property (p_sleep_entry) else $error("sleep not entered");

  property p_suspend_entry;
    @(posedge sys_clk) disable iff (reset)
      (state == PMW_RUN && wr_wake && reg_wdata[PMW_BIT_SUSPEND] && !reg_wdata[PMW_BIT_SLEEP]
       && !flags_any) |=> state == PMW_LOWPWR && !lowpwr_sleep;
  endproperty
  a_suspend_entry: assert property (p_suspend_entry) else $error("no suspend");

  property p_idle_entry;
    @(posedge sys_clk) disable iff (reset)
      (state == PMW_RUN && wr_ctrl && reg_wdata[PMW_BIT_IDLE] && !reg_wdata[PMW_BIT_STOP])
      |=> state == PMW_IDLE;
  endproperty
  a_idle_entry: assert property (p_idle_entry) else $error("idle not entered");

  property p_idle_hold;
    @(posedge sys_clk) disable iff (reset)
      (state == PMW_IDLE && !wake_interrupt) |=> state == PMW_IDLE;
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("idle left early");

  property p_stop_hold;
    @(posedge sys_clk) disable iff (reset)
      state == PMW_STOP |=> state == PMW_STOP;
  endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("stop left early");

  property p_lpo;
    @(posedge sys_clk) disable iff (reset)
      flags_any |=> lpo_keep_on;
  endproperty
  a_lpo: assert property (p_lpo) else $error("oscillator released with flag");

  property p_rtc_out;
    @(posedge sys_clk) disable iff (reset)
      mode_opts[PMW_BIT_RTC_OUT_EN] |=> rtc_out == $past(rtc_clk_in);
  endproperty
  a_rtc_out: assert property (p_rtc_out) else $error("clock output wrong");

  property p_pin_flag;
    @(posedge sys_clk) disable iff (reset)
      (!reset_pin_n && $past(reset_pin_n)) |=> flags[PMW_BIT_RESET_PIN];
  endproperty
  a_pin_flag: assert property (p_pin_flag) else $error("pin flag not set");

  property p_wake_oe;
    @(posedge sys_clk) disable iff (reset)
      wr_mode |-> ##2 wake_req_oe == $past(reg_wdata[PMW_BIT_WAKE_OUT_EN], 2);
  endproperty
  a_wake_oe: assert property (p_wake_oe) else $error("wake pin enable wrong");

  property p_mon_off;
    @(posedge sys_clk) disable iff (reset)
      wr_mode |-> ##2 battery_monitor_off == $past(reg_wdata[PMW_BIT_MON_OFF], 2);
  endproperty
  a_mon_off: assert property (p_mon_off) else $error("monitor disable wrong");
endmodule
`default_nettype wire

// [tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
  import pmw_pkg::*;
  logic sys_clk, reset, reg_wr, reg_rd, reset_pin_n, rtc_osc_fail, rtc_alarm, port_match;
  logic comparator_out, rtc_clk_in, any_reset_src, wake_interrupt, lpo_keep_on, rtc_out;
  logic rtc_out_oe, wake_req_out, wake_req_oe, battery_monitor_off, full_por_req;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d, w, sel, en;
  logic [1:0] power_state;
  integer n_fail, num_checks, seed, i, j;
  pmw_power_mode_wakeup pmw_power_mode_wakeup_i (.sys_clk(sys_clk), .reset(reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .reset_pin_n(reset_pin_n), .rtc_osc_fail(rtc_osc_fail),
    .rtc_alarm(rtc_alarm), .port_match(port_match), .comparator_out(comparator_out),
    .rtc_clk_in(rtc_clk_in), .any_reset_src(any_reset_src), .wake_interrupt(wake_interrupt),
    .power_state(power_state), .lpo_keep_on(lpo_keep_on), .rtc_out(rtc_out),
    .rtc_out_oe(rtc_out_oe), .wake_req_out(wake_req_out), .wake_req_oe(wake_req_oe),
    .battery_monitor_off(battery_monitor_off), .full_por_req(full_por_req));
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  // Oscillator stand-in toggles every cycle
  always @(posedge sys_clk) rtc_clk_in <= ~rtc_clk_in;
  initial begin
    #(50 * 20000);
    n_fail++;
    print_verdict;
  end
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] exp_ctrl(input logic [7:0] v);
    return {v[7:2], 2'b00};
  endfunction
  function automatic logic [7:0] exp_mode(input logic [7:0] v);
    return {v[7:5], 5'h00};
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  // Write then read with no idle cycle between the strobes
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] v, output logic [7:0] r);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 r = reg_rdata;
  endtask
  // Source 4 is the reset pin, whose event is a falling edge
  task automatic ev(input int k, input logic lv);
    @(posedge sys_clk);
    case (k)
      0: comparator_out <= lv;
      1: port_match <= lv;
      2: rtc_alarm <= lv;
      3: rtc_osc_fail <= lv;
      default: reset_pin_n <= ~lv;
    endcase
  endtask
  task automatic pulse(input int k);
    ev(k, 1'b1);
    ev(k, 1'b0);
  endtask
  task automatic wait_state(input logic [1:0] s);
    int n;
    n = 0;
    while (power_state !== s && n < 10) begin
      tick(1);
      n++;
    end
    check({6'h00, power_state}, {6'h00, s});
  endtask
  task automatic do_reset(input int n);
    @(posedge sys_clk);
    reset <= 1'b1;
    repeat (n) @(posedge sys_clk);
    reset <= 1'b0;
    tick(1);
  endtask
  task automatic print_verdict;
    $display("checks=%0d failures=%0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 69396;
    n_fail = 0;
    num_checks = 0;
    {reset, reg_wr, reg_rd, reg_addr, reg_wdata} = {1'b1, 18'h0};
    {rtc_osc_fail, rtc_alarm, port_match, comparator_out, rtc_clk_in} = 5'h00;
    {any_reset_src, wake_interrupt, reset_pin_n} = 3'b001;
    do_reset(5);
    rd(PMW_ADDR_CONTROL, d); check(d, PMW_CONTROL_RESET);
    rd(PMW_ADDR_MODE_OPTIONS, d); check(d, PMW_MODE_RESET);
    for (i = 0; i < 8; i++) begin
      w = 8'($random(seed));
      wr_rd(PMW_ADDR_CONTROL, w & 8'hFC, d); check(d, exp_ctrl(w));
      wr(PMW_ADDR_MODE_OPTIONS, w);
      rd(PMW_ADDR_MODE_OPTIONS, d); check(d, exp_mode(w));
      check({rtc_out_oe, wake_req_oe, battery_monitor_off, 5'h00}, exp_mode(w));
      check({7'h00, rtc_out}, {7'h00, ~rtc_clk_in & w[7]});
      wr(8'h40 | w[3:0], w);
      rd(8'h40 | w[3:0], d); check(d, 8'h00);
    end
    wr(PMW_ADDR_MODE_OPTIONS, 8'h40);
    wr(PMW_ADDR_CONTROL, 8'h01); wait_state(PMW_IDLE);
    pulse(9);
    @(posedge sys_clk) wake_interrupt <= 1'b1;
    @(posedge sys_clk) wake_interrupt <= 1'b0;
    wr(PMW_ADDR_WAKE_CONFIG, 8'h20);
    wait_state(PMW_RUN);
    rd(PMW_ADDR_CONTROL, d); check(d & 8'h03, 8'h00);
    // Flags set with no enables; a pending flag must block sleep
    for (i = 0; i < 5; i++) begin
      pulse(i);
      tick(3);
      rd(PMW_ADDR_WAKE_CONFIG, d); check(d & 8'h1F, 8'h01 << i);
      check({7'h00, lpo_keep_on}, 8'h01);
      wr(PMW_ADDR_WAKE_CONFIG, 8'h80);
      tick(2);
      check({6'h00, power_state}, 8'h00);
      wr(PMW_ADDR_WAKE_CONFIG, 8'h20);
      tick(1);
      rd(PMW_ADDR_WAKE_CONFIG, d); check(d & 8'h1F, 8'h00);
      check({7'h00, lpo_keep_on}, 8'h00);
    end
    // Even passes sleep, odd passes suspend; pass 4 relies on the reset pin alone
    for (i = 0; i < 5; i++) begin
      sel = (i % 2) ? 8'h40 : 8'h80;
      en = (i < 4) ? (8'h01 << i) : 8'h00;
      j = (i + 1) % 4;
      wr(PMW_ADDR_WAKE_CONFIG, sel | en);
      tick(1);
      check({6'h00, power_state}, {6'h00, PMW_LOWPWR});
      if (sel[7]) check({7'h00, wake_req_out}, 8'h00);
      pulse(j);
      tick(3);
      check({6'h00, power_state}, {6'h00, PMW_LOWPWR});
      pulse(i);
      // Read lands in the first clock after the suspend wake
      if (sel[6]) begin
        rd(PMW_ADDR_WAKE_CONFIG, d); check(d & 8'h1F, 8'h00);
      end
      wait_state(PMW_RUN);
      tick(2);
      rd(PMW_ADDR_WAKE_CONFIG, d); check(d & 8'h1F, (8'h01 << i) | (8'h01 << j));
      check({7'h00, wake_req_out}, 8'h01);
      wr(PMW_ADDR_WAKE_CONFIG, 8'h20);
    end
    wr(PMW_ADDR_MODE_OPTIONS, 8'h20);
    @(posedge sys_clk) any_reset_src <= 1'b1;
    @(posedge sys_clk) any_reset_src <= 1'b0;
    #1;
    check({7'h00, full_por_req}, 8'h01);
    do_reset(1);
    check({7'h00, battery_monitor_off}, 8'h00);
    // Stop ignores interrupts and is left only by reset
    wr(PMW_ADDR_CONTROL, 8'h02); wait_state(PMW_STOP);
    @(posedge sys_clk) wake_interrupt <= 1'b1;
    @(posedge sys_clk) wake_interrupt <= 1'b0;
    tick(3);
    check({6'h00, power_state}, {6'h00, PMW_STOP});
    do_reset(1);
    wait_state(PMW_RUN);
    print_verdict;
  end
endmodule
`default_nettype wire
